// >>> verilog/uart_rx_clock_data_recovery.v
// oversampling start detection and majority-vote bit recovery for an async receiver
`timescale 1ns/1ps
`include "rx_recovery_defs.vh"
module uart_rx_clock_data_recovery (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // configuration
  input  wire        double_speed_select,
  input  wire [3:0]  frame_bits,
  input  wire        sample_tick,
  // serial line
  input  wire        rxd,
  // recovered frame
  output reg         frame_valid,
  output wire [9:0]  receive_data_port,
  output wire        frame_error_flag,
  output wire        busy
);
  localparam IDLE  = 2'h0;
  localparam START = 2'h1;
  localparam DATA  = 2'h2;
  localparam STOP  = 2'h3;
  // IDLE waits for a falling edge seen at a tick
  // START votes the start bit and drops spikes
  // DATA votes each data and parity bit
  // STOP votes the first stop bit only

  // reset and line synchronisers
  reg        rst_s1;
  reg        rst_s2;
  reg        rxd_s1;
  reg        rxd_s2;
  reg        rxd_prev;
  // recovery state and per-frame settings
  reg [1:0]  state;
  reg [4:0]  sample;
  reg [3:0]  bit_idx;
  reg [3:0]  nbits;
  reg        dbl;
  reg [2:0]  votes;
  reg [9:0]  shift;
  reg        next_bit;
  reg [9:0]  next_shift;
  wire [10:0] frame_q;

  // one mode select shared by every per-mode count
  function [4:0] mode_pick;
    input       fast;
    input [4:0] slow_val;
    input [4:0] fast_val;
    begin
      mode_pick = fast ? fast_val : slow_val;
    end
  endfunction

  function maj3;
    input [2:0] v;
    begin
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    end
  endfunction

  // out-of-range lengths clamped rather than refused
  function [3:0] clamp_bits;
    input [3:0] b;
    begin
      if (b < `BITS_MIN)
        clamp_bits = `BITS_MIN;
      else if (b > `BITS_MAX)
        clamp_bits = `BITS_MAX;
      else
        clamp_bits = b;
    end
  endfunction

  // all state leaves reset on one edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // line idles high, so sync flops reset to one to avoid a false edge
  always @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end else begin
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
    end
  end

  // per-mode counts follow the latched mode, so a frame keeps one rate
  wire [4:0] spb        = mode_pick(dbl, `SPB_NORMAL, `SPB_DOUBLE);
  wire [4:0] vote_first = mode_pick(dbl, `VOTE_FIRST_N, `VOTE_FIRST_D);
  wire [4:0] vote_last  = mode_pick(dbl, `VOTE_LAST_N, `VOTE_LAST_D);
  // three-sample window around the bit centre
  wire       in_vote    = (sample >= vote_first) && (sample <= vote_last);
  wire       vote_done  = (sample == vote_last);
  wire [2:0] votes_now  = {votes[1:0], rxd_s2};
  // high majority at the last start vote means a spike
  wire       start_noise = vote_done && maj3(votes_now);
  wire       last_bit    = (bit_idx == nbits - 4'h1);

  // two stored votes plus the live sample
  always @* begin
    next_bit = maj3(votes_now);
    next_shift = shift;
    next_shift[bit_idx] = next_bit;
  end

  // sampling state machine, moves on ticks only
  always @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      state       <= IDLE;
      sample      <= 5'h00;
      bit_idx     <= 4'h0;
      nbits       <= `BITS_MIN;
      dbl         <= 1'b0;
      votes       <= 3'h0;
      shift       <= 10'h000;
      rxd_prev    <= 1'b1;
      frame_valid <= 1'b0;
    end else begin
      frame_valid <= 1'b0;
      if (sample_tick) begin
        rxd_prev <= rxd_s2;
        case (state)
          IDLE: begin
            // counter parked at zero between frames
            sample <= 5'h00;
            if (rxd_prev && !rxd_s2) begin
              // mode and length latched per frame so mid-frame changes cannot tear it
              state   <= START;
              sample  <= 5'h02;
              dbl     <= double_speed_select;
              nbits   <= clamp_bits(frame_bits);
              bit_idx <= 4'h0;
              shift   <= 10'h000;
            end
          end

          START: begin
            sample <= sample + 5'h01;
            if (in_vote) begin
              votes <= votes_now;
            end
            if (vote_done) begin
              if (start_noise) begin
                state <= IDLE;
              end
            end
            if (sample == spb) begin
              state  <= DATA;
              sample <= 5'h01;
            end
          end

          DATA: begin
            sample <= sample + 5'h01;
            if (in_vote) begin
              votes <= votes_now;
            end
            if (vote_done) begin
              // bit written once its three votes are in
              shift <= next_shift;
            end
            if (sample == spb) begin
              sample <= 5'h01;
              if (last_bit) begin
                state <= STOP;
              end else begin
                bit_idx <= bit_idx + 4'h1;
              end
            end
          end

          STOP: begin
            sample <= sample + 5'h01;
            if (in_vote) begin
              votes <= votes_now;
            end
            if (vote_done) begin
              // rest of the stop bit and any extra stop bits are not waited for
              frame_valid <= 1'b1;
              state       <= IDLE;
              sample      <= 5'h00;
              rxd_prev    <= rxd_s2;
            end
          end

          default: state <= IDLE;
        endcase
      end
    end
  end

  // same strobe as frame_valid so data and flag land together
  wire frame_wr = sample_tick && (state == STOP) && vote_done;

  // one register for data and flag keeps them paired; flag is the inverted stop vote
  rx_frame_reg #(
    .WIDTH (11)
  ) u_frame (
    .clk   (clk),
    .rst_n (rst_s2),
    .wr    (frame_wr),
    .wdata ({~maj3(votes_now), shift}),
    .rdata (frame_q)
  );

  // data and flag straight from the frame register, busy decoded from the state
  assign receive_data_port = frame_q[9:0];
  assign frame_error_flag  = frame_q[10];
  assign busy              = (state != IDLE);
endmodule

// >>> inc/rx_recovery_defs.vh
// constants for the receive clock and data recovery block
`ifndef RX_RECOVERY_DEFS_VH
`define RX_RECOVERY_DEFS_VH
`define SPB_NORMAL     5'h10
`define SPB_DOUBLE     5'h08
`define VOTE_FIRST_N   5'h08
`define VOTE_LAST_N    5'h0A
`define VOTE_FIRST_D   5'h04
`define VOTE_LAST_D    5'h06
`define BITS_MIN       4'h5
`define BITS_MAX       4'hA
`endif

// >>> verilog/rx_frame_reg.v
// output register holding one recovered frame and its frame error flag
`timescale 1ns/1ps
module rx_frame_reg #(
  parameter WIDTH = 11
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // write side
  input  wire             wr,
  input  wire [WIDTH-1:0] wdata,
  // read data
  output reg  [WIDTH-1:0] rdata
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= {WIDTH{1'b0}};
    end else if (wr) begin
      rdata <= wdata;
    end
  end
endmodule

// >>> tb/rx_cdr_props.sv
// assertion checker for the receive recovery block
`timescale 1ns/1ps
module rx_cdr_props (
  input wire logic       clk, rst_n, double_speed_select, sample_tick, rxd,
  input wire logic [3:0] frame_bits,
  input wire logic       frame_valid, frame_error_flag, busy,
  input wire logic [9:0] receive_data_port
);
  wire [3:0] fb = frame_bits < 4'h5 ? 4'h5 : (frame_bits > 4'hA ? 4'hA : frame_bits);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_valid_one_cycle: assert property (frame_valid |=> !frame_valid)
    else $error("frame valid held");
  a_data_holds: assert property ($changed(receive_data_port) |-> frame_valid)
    else $error("data moved without frame");
  a_flag_holds: assert property ($changed(frame_error_flag) |-> frame_valid)
    else $error("flag moved without frame");
  a_idle_no_tick: assert property (!busy && !sample_tick |=> !busy)
    else $error("woke without tick");
  a_valid_on_tick: assert property (frame_valid |-> $past(sample_tick))
    else $error("frame not one clock after tick");
  a_upper_clear: assert property (frame_valid |-> (receive_data_port >> fb) == 10'h000)
    else $error("unused bits set");
  a_start_low: assert property ($rose(busy) |-> !$past(rxd, 2) || !$past(rxd, 3))
    else $error("busy without low line");
  a_valid_busy: assert property (frame_valid |-> $past(busy, 2))
    else $error("frame outside reception");
endmodule
bind uart_rx_clock_data_recovery rx_cdr_props u_props (.clk(clk), .rst_n(rst_n),
  .double_speed_select(double_speed_select), .sample_tick(sample_tick), .rxd(rxd),
  .frame_bits(frame_bits), .frame_valid(frame_valid), .frame_error_flag(frame_error_flag),
  .busy(busy), .receive_data_port(receive_data_port));

// >>> tb/serial_tx_model.sv
// behavioural remote transmitter on the serial line
`timescale 1ns/1ps
module serial_tx_model (
  input wire logic        clk, tick, go,
  input wire logic [11:0] bits,
  input wire logic [3:0]  nbits,
  input wire logic [4:0]  spb,
  output logic            line, done
);
  logic       active = 1'b0;
  logic [3:0] pos;
  logic [4:0] sub;
  // exact bit period: zero rate error, inside either tolerance
  assign line = active ? bits[pos] : 1'b1;
  assign done = ~active;
  always @(posedge clk) begin
    if (go) begin
      active <= 1'b1;
      pos    <= 4'h0;
      sub    <= 5'h00;
    end else if (active && tick) begin
      if (sub == spb - 5'h01) begin
        sub <= 5'h00;
        pos <= pos + 4'h1;
        if (pos == nbits + 4'h1) active <= 1'b0;
      end else sub <= sub + 5'h01;
    end
  end
endmodule

// >>> tb/testbench.sv
// self-checking bench for the receive recovery block
`timescale 1ns/1ps
module testbench;
  logic        clk, rst_n, dss, tick, go, done, line, spike, fv, fe, busy;
  logic [3:0]  fb;
  logic [11:0] bits;
  logic [9:0]  rdp;
  logic [4:0]  spb;
  logic [1:0]  tc;
  logic [31:0] seed;
  int          err_count, tests_run, cyc, n;
  wire         rxd = line & ~spike;
  uart_rx_clock_data_recovery u_dut (.clk(clk), .rst_n(rst_n), .double_speed_select(dss),
    .frame_bits(fb), .sample_tick(tick), .rxd(rxd), .frame_valid(fv),
    .receive_data_port(rdp), .frame_error_flag(fe), .busy(busy));
  serial_tx_model u_tx (.clk(clk), .tick(tick), .go(go), .bits(bits), .nbits(fb),
    .spb(spb), .line(line), .done(done));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [10:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic frame(input logic m, input int nb, input logic stopv);
    int k;
    logic [9:0] d;
    seed = xs(seed);
    d = seed[9:0] & ((10'h001 << nb) - 10'h001);
    @(posedge clk);
    dss  <= m;
    fb   <= nb[3:0];
    spb  <= m ? 5'h08 : 5'h10;
    bits <= 12'({d, 1'b0}) | (12'(stopv) << (nb + 1));
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    while (fv !== 1'b1 && k < 3000) begin @(negedge clk); k++; end
    if (fv !== 1'b1) err_count++;
    check({fe, rdp}, {~stopv, d});
    k = 0;
    while (done !== 1'b1 && k < 3000) begin @(negedge clk); k++; end
    $display("frame mode %0d bits %0d done", m, nb);
  endtask
  initial begin clk = 0; forever #5 clk = ~clk; end
  // ticks every fourth clock so the sync delay stays inside one sample
  always @(posedge clk) begin
    tc   <= tc + 2'h1;
    tick <= (tc == 2'h3);
    cyc++;
    if (cyc > 60000) begin err_count++; give_verdict(); end
  end
  initial begin
    rst_n = 0; dss = 0; fb = 4'h8; tick = 0; go = 0; spike = 0; spb = 5'h10;
    bits = 12'h000; tc = 2'h0; seed = 50;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      dss   <= m[0];
      spike <= 1'b1;
      repeat (m ? 8 : 16) @(posedge clk);
      spike <= 1'b0;
      n = 0;
      repeat (120) @(negedge clk) if (fv) n++;
      check(11'(n), 11'h000);
      check({10'h000, busy}, 11'h000);
      $display("noise spike mode %0d done", m);
      for (int r = 0; r < 2; r++)
        for (int nb = 5; nb <= 10; nb++) frame(m[0], nb, r[0]);
    end
    give_verdict();
  end
endmodule
